// file: rtl/cell_params.svh
// Constants for the programmable logic cell: table masks, chain geometry.
// Assumes inclusion by the cell's design files only.
//
// Function
// - Carry input feeds the look-up table and onward carry to higher bit.
// - Chains longer than eight cells continue two clusters on, keeping parity.
// - Carry chain ends at cluster eighteen; cluster nineteen starts a fresh one.
// - n-bit adder uses n+1 cells; last carry becomes ordinary logic input.
// - Adder sum either bypasses the register or is registered as accumulator.
// - Cascade joins cell outputs by AND, or OR via inversion.
// - Cascade chains over eight bits hop clusters keeping even or odd parity.
// - Cascade chain ends at cluster eighteen; nineteen begins a new one.
// - Seven inputs routed per mode; clock, clear, preset control the register.
// - Register has synchronous clock enable in every mode; input one may drive it.
// - Normal mode table takes data inputs, carry or input three selectable.
// - Normal mode table output combines with cascade input into cascade output.
// - Packed cell registers input four; table makes a 3-input function.
// - Packed register keeps enable, clear, preset; drives global or local output.
// - Arithmetic mode: two 3-input tables make result and carry output.
// - Arithmetic mode allows the cascade chain together with the carry chain.
// - Up/down counter has count enable, clock enable, direction and loading.
// - Counter uses count-bit table, carry table and 2-to-1 load multiplexer.
// - Counter data loads asynchronously through clear and preset controls; here those only force 0 or 1, and load is synchronous.
// - Clearable counter uses synchronous clear in place of the cascade input.
// - Clearable counter ANDs the load multiplexer output with the clear.
// - Each cell has a 4-input table and register with clock enable.
// - Clear and preset are active low; unused ones are held high.
`ifndef CELL_PARAMS_SVH
`define CELL_PARAMS_SVH

// Cells per cluster, and last cluster before the memory block
`define CLUSTER_CELLS     8
`define SPLIT_CLUSTER     18
`define NUM_CLUSTERS      36
`define CLUSTER_HOP       2

// Counter tables, index {direction, carry_in, q}
`define COUNT_BIT_MASK    8'h66
`define COUNT_CARRY_MASK  8'h84

// Register value after synchronous reset
`define REG_RESET_VALUE   1'h0

`endif

// file: rtl/cell_pkg.sv
// Types shared by the programmable logic cell.
// Assumes nothing beyond the compile order.
package cell_pkg;

	typedef enum logic [1:0] {
		MODE_NORMAL    = 2'h0,
		MODE_ARITH     = 2'h1,
		MODE_UPDOWN    = 2'h3,
		MODE_CLEARABLE = 2'h2
	} cell_mode_type;

endpackage

// file: rtl/logic_cell.sv
// One programmable logic cell: table, register, carry and cascade chains.
// Assumes all data and control inputs come from fabric logic on clk.
`timescale 1ns/1ps

`include "cell_params.svh"

module logic_cell
	import cell_pkg::*;
#(
	parameter int CLUSTER_CELLS = `CLUSTER_CELLS,
	parameter int SPLIT_CLUSTER = `SPLIT_CLUSTER,
	parameter int NUM_CLUSTERS  = `NUM_CLUSTERS
)
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic [1:0]  mode,
	input  wire logic [15:0] lut_mask,
	input  wire logic        carry_select,
	input  wire logic        cascade_use,
	input  wire logic        cascade_or,
	input  wire logic        reg_bypass,
	input  wire logic        packing,
	input  wire logic        packed_reg_global,
	input  wire logic        enable_from_one,
	input  wire logic        cell_input_one,
	input  wire logic        cell_input_two,
	input  wire logic        cell_input_three,
	input  wire logic        cell_input_four,
	input  wire logic        carry_in,
	input  wire logic        cascade_in,
	input  wire logic        clear_n,
	input  wire logic        preset_n,
	input  wire logic [5:0]  cluster_index,
	input  wire logic [2:0]  cell_slot,
	output logic             local_out,
	output logic             global_out,
	output logic             carry_out,
	output logic             cascade_out,
	output logic             reg_q,
	output logic             chain_link,
	output logic [5:0]       chain_next_cluster
);

	// ************************************************************
	// Parameter checks
	// ************************************************************
	generate
		if (CLUSTER_CELLS != 8)
		begin : bad_cells
			$error("logic_cell: cell_slot is 3 bits, clusters hold 8");
		end
		if (SPLIT_CLUSTER < 1 || SPLIT_CLUSTER >= NUM_CLUSTERS)
		begin : bad_split
			$error("logic_cell: split cluster outside the row");
		end
		if (NUM_CLUSTERS > 61)
		begin : bad_row
			$error("logic_cell: cluster index is 6 bits");
		end
	endgenerate

	cell_mode_type cell_mode;
	logic          q;
	logic          next_q;
	logic [3:0]    main_index;
	logic [2:0]    arith_index;
	logic [2:0]    count_index;
	logic [15:0]   main_mask;
	logic          main_result;
	logic          sum_result;
	logic          arith_carry;
	logic          count_bit;
	logic          count_carry;
	logic          direction;
	logic          load_mux;
	logic          reg_enable;
	logic          table_out;
	logic          reg_source;
	logic [6:0]    hop;

	assign cell_mode = cell_mode_type'(mode);

	// ************************************************************
	// Look-up tables
	// ************************************************************
	// Packed cells drop input four so the table is a 3-input function
	always_comb
	begin
		main_index[0] = cell_input_one;
		main_index[1] = cell_input_two;
		main_index[2] = carry_select ? carry_in : cell_input_three;
		main_index[3] = packing ? 1'h0 : cell_input_four;
		main_mask     = lut_mask;
	end

	lookup_table
	#(
		.INPUTS (4)
	)
	main_table
	(
		.mask   (main_mask),
		.index  (main_index),
		.result (main_result)
	);

	// Arithmetic halves: low byte is the result, high byte the carry
	always_comb
	begin
		arith_index = {carry_in, cell_input_two, cell_input_one};
	end

	lookup_table
	#(
		.INPUTS (3)
	)
	sum_table
	(
		.mask   (lut_mask[7:0]),
		.index  (arith_index),
		.result (sum_result)
	);

	lookup_table
	#(
		.INPUTS (3)
	)
	carry_table
	(
		.mask   (lut_mask[15:8]),
		.index  (arith_index),
		.result (arith_carry)
	);

	// Counter direction rides on the cascade input; clearable counts up
	always_comb
	begin
		if (cell_mode == MODE_UPDOWN)
		begin
			direction = cascade_in;
		end
		else
		begin
			direction = 1'h1;
		end
		count_index = {direction, carry_in, q};
	end

	lookup_table
	#(
		.INPUTS (3)
	)
	count_table
	(
		.mask   (`COUNT_BIT_MASK),
		.index  (count_index),
		.result (count_bit)
	);

	lookup_table
	#(
		.INPUTS (3)
	)
	fast_carry_table
	(
		.mask   (`COUNT_CARRY_MASK),
		.index  (count_index),
		.result (count_carry)
	);

	// ************************************************************
	// Register input selection
	// ************************************************************
	// Counters: input two enables counting, three selects load of four
	always_comb
	begin
		load_mux = cell_input_three ? cell_input_four : count_bit;
		if (cell_mode == MODE_CLEARABLE)
		begin
			load_mux = load_mux & cascade_in;
		end
		reg_enable = enable_from_one ? cell_input_one : 1'h1;
		table_out  = main_result;
		reg_source = main_result;
		case (cell_mode)
			MODE_NORMAL:
			begin
				table_out  = main_result;
				reg_source = packing ? cell_input_four : main_result;
			end
			MODE_ARITH:
			begin
				table_out  = sum_result;
				reg_source = sum_result;
			end
			MODE_UPDOWN, MODE_CLEARABLE:
			begin
				table_out  = load_mux;
				if (cell_input_two || cell_input_three)
				begin
					reg_source = load_mux;
				end
				else
				begin
					reg_source = q;
				end
			end
			default:
			begin
				table_out  = main_result;
				reg_source = main_result;
			end
		endcase
		next_q = q;
		if (rst)
		begin
			next_q = `REG_RESET_VALUE;
		end
		else if (reg_enable)
		begin
			next_q = reg_source;
		end
	end

	// ************************************************************
	// Cell register
	// ************************************************************
	// Active-low clear beats preset; each forces a constant only
	always_ff @(posedge clk or negedge clear_n or negedge preset_n)
	begin
		if (!clear_n)
		begin
			q <= 1'h0;
		end
		else if (!preset_n)
		begin
			q <= 1'h1;
		end
		else if (ce)
		begin
			q <= next_q;
		end
	end

	// ************************************************************
	// Outputs and chains
	// ************************************************************
	always_comb
	begin
		reg_q = q;
		if (packing && cell_mode == MODE_NORMAL)
		begin
			global_out = packed_reg_global ? q : table_out;
			local_out  = packed_reg_global ? table_out : q;
		end
		else
		begin
			global_out = reg_bypass ? table_out : q;
			local_out  = global_out;
		end
		case (cell_mode)
			MODE_NORMAL:    carry_out = carry_in;
			MODE_ARITH:     carry_out = arith_carry;
			MODE_UPDOWN:    carry_out = count_carry;
			MODE_CLEARABLE: carry_out = count_carry;
			default:        carry_out = carry_in;
		endcase
		// Counters use the cascade input as a control, so it is not combined into cascade_out
		if (cascade_use &&
			(cell_mode == MODE_NORMAL || cell_mode == MODE_ARITH))
		begin
			if (cascade_or)
			begin
				cascade_out = ~(~table_out & ~cascade_in);
			end
			else
			begin
				cascade_out = table_out & cascade_in;
			end
		end
		else
		begin
			cascade_out = table_out;
		end
	end

	// Where this cell's carry and cascade lead, from its row position
	always_comb
	begin
		hop                = 7'(cluster_index) + 7'(`CLUSTER_HOP);
		chain_link         = 1'h1;
		chain_next_cluster = cluster_index;
		if (cell_slot == 3'(CLUSTER_CELLS - 1))
		begin
			chain_next_cluster = hop[5:0];
			if (cluster_index <= 6'(SPLIT_CLUSTER) &&
				hop > 7'(SPLIT_CLUSTER))
			begin
				chain_link = 1'h0;
			end
			if (hop > 7'(NUM_CLUSTERS))
			begin
				chain_link = 1'h0;
			end
		end
	end

endmodule

// file: rtl/lookup_table.sv
// Look-up table of a programmable width, evaluated from a truth mask.
// Assumes the mask is held steady as configuration.
`timescale 1ns/1ps

module lookup_table
#(
	parameter int INPUTS = 4
)
(
	input  wire logic [(1<<INPUTS)-1:0] mask,
	input  wire logic [INPUTS-1:0]      index,
	output logic                        result
);

	generate
		if (INPUTS < 1 || INPUTS > 6)
		begin : bad_width
			$error("lookup_table: INPUTS must be 1 to 6");
		end
	endgenerate

	always_comb
	begin
		result = mask[index];
	end

endmodule

// file: tb/logic_cell_monitor.sv
// Concurrent checks on the logic cell ports.
// Assumes binding to logic_cell, one clock, reset rst.
`timescale 1ns/1ps

module logic_cell_monitor
	import cell_pkg::*;
#(
	parameter int SPLIT_CLUSTER = 18
)
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        ce,
	input wire logic        carry_select,
	input wire logic        cascade_use,
	input wire logic        cascade_or,
	input wire logic        packing,
	input wire logic        enable_from_one,
	input wire logic        cell_input_one,
	input wire logic        cell_input_two,
	input wire logic        cell_input_three,
	input wire logic        cell_input_four,
	input wire logic        carry_in,
	input wire logic        cascade_in,
	input wire logic        clear_n,
	input wire logic        preset_n,
	input wire logic        carry_out,
	input wire logic        cascade_out,
	input wire logic        reg_q,
	input wire logic        chain_link,
	input wire logic [1:0]  mode,
	input wire logic [15:0] lut_mask,
	input wire logic [5:0]  cluster_index,
	input wire logic [5:0]  chain_next_cluster,
	input wire logic [2:0]  cell_slot
);
	// ****************
	// Checks
	// ****************
	logic t, go;
	assign t = lut_mask[{cell_input_four,
		carry_select ? carry_in : cell_input_three,
		cell_input_two, cell_input_one}];
	assign go = ce && !enable_from_one && clear_n && preset_n;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_clear; !clear_n |-> !reg_q; endproperty
	a_clear: assert property (p_clear)
		else $error("register not cleared");
	property p_preset; clear_n && !preset_n |-> reg_q; endproperty
	a_preset: assert property (p_preset)
		else $error("register not preset");
	property p_hold;
		!ce && clear_n && preset_n ##1 clear_n && preset_n
			|-> $stable(reg_q);
	endproperty
	a_hold: assert property (p_hold)
		else $error("register moved while frozen");
	property p_arith;
		mode == MODE_ARITH |-> carry_out ==
			lut_mask[{1'b1, carry_in, cell_input_two, cell_input_one}];
	endproperty
	a_arith: assert property (p_arith)
		else $error("arithmetic carry wrong");
	property p_cascade;
		mode == MODE_NORMAL && cascade_use && !packing |->
			cascade_out == (cascade_or ? t | cascade_in : t & cascade_in);
	endproperty
	a_cascade: assert property (p_cascade)
		else $error("cascade output wrong");
	property p_dir;
		mode == MODE_UPDOWN |-> carry_out ==
			((cascade_in ? reg_q : !reg_q) && carry_in);
	endproperty
	a_dir: assert property (p_dir)
		else $error("counter carry wrong");
	property p_count;
		mode == MODE_UPDOWN && go && cell_input_two && !cell_input_three
			&& carry_in ##1 clear_n && preset_n |-> reg_q != $past(reg_q);
	endproperty
	a_count: assert property (p_count)
		else $error("counter did not step");
	property p_sclr;
		mode == MODE_CLEARABLE && go && !cascade_in &&
			(cell_input_two || cell_input_three) |=> !reg_q;
	endproperty
	a_sclr: assert property (p_sclr)
		else $error("synchronous clear missed");
	property p_link;
		cell_slot == 3'h7 && chain_link |->
			chain_next_cluster == cluster_index + 6'h02 &&
			!(cluster_index <= SPLIT_CLUSTER &&
			chain_next_cluster > SPLIT_CLUSTER);
	endproperty
	a_link: assert property (p_link)
		else $error("chain link wrong");
endmodule

bind logic_cell logic_cell_monitor #(.SPLIT_CLUSTER(SPLIT_CLUSTER)) mon_u
	(.clk, .rst, .ce, .carry_select, .cascade_use, .cascade_or, .packing,
	.enable_from_one, .cell_input_one, .cell_input_two, .cell_input_three,
	.cell_input_four, .carry_in, .cascade_in, .clear_n, .preset_n,
	.carry_out, .cascade_out, .reg_q, .chain_link, .mode, .lut_mask,
	.cluster_index, .chain_next_cluster, .cell_slot);

// file: tb/logic_cell_test.sv
// Self-checking bench for one logic cell.
// Assumes 40 MHz clock and a neighbour model on the chains.
`timescale 1ns/1ps

module logic_cell_test;
	import cell_pkg::*;
	logic clk, rst, ce, carry_select, cascade_use, cascade_or, reg_bypass;
	logic packing, packed_reg_global, enable_from_one, cell_input_one;
	logic cell_input_two, cell_input_three, cell_input_four, carry_src;
	logic cascade_src, carry_in, cascade_in, clear_n, preset_n;
	logic local_out, global_out, carry_out, cascade_out, reg_q, chain_link;
	logic [1:0]  mode;
	logic [15:0] lut_mask;
	logic [5:0]  cluster_index, chain_next_cluster;
	logic [2:0]  cell_slot;
	int          n_fail, tests_run;

	neighbour_cell nb_u (.carry_src, .cascade_src, .carry_in, .cascade_in);
	logic_cell dut_u (.clk, .rst, .ce, .mode, .lut_mask, .carry_select,
		.cascade_use, .cascade_or, .reg_bypass, .packing,
		.packed_reg_global, .enable_from_one, .cell_input_one,
		.cell_input_two, .cell_input_three, .cell_input_four, .carry_in,
		.cascade_in, .clear_n, .preset_n, .cluster_index, .cell_slot,
		.local_out, .global_out, .carry_out, .cascade_out, .reg_q,
		.chain_link, .chain_next_cluster);

	// ****************
	// Tasks
	// ****************
	task automatic check(input logic [5:0] got, input logic [5:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic tick;
		@(posedge clk);
		#1;
	endtask

	task automatic give_verdict;
		$display("comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic t_normal;
		mode = MODE_NORMAL;
		lut_mask = 16'h8000;
		{cell_input_four, cell_input_two, cell_input_one} = 3'h7;
		carry_src = 1'h1;
		carry_select = 1'h1;
		tick();
		check_bit(local_out, 1'h1);
		check_bit(global_out, 1'h1);
		carry_select = 1'h0;
		tick();
		check_bit(local_out, 1'h0);
		carry_select = 1'h1;
		cascade_use = 1'h1;
		tick();
		check_bit(cascade_out, 1'h0);
		cascade_src = 1'h1;
		tick();
		check_bit(cascade_out, 1'h1);
		cascade_or = 1'h1;
		carry_src = 1'h0;
		tick();
		check_bit(cascade_out, 1'h1);
		$display("normal mode done");
	endtask

	task automatic t_arith;
		mode = MODE_ARITH;
		cascade_use = 1'h0;
		cascade_or = 1'h0;
		lut_mask = 16'he896;
		for (int k = 0; k < 8; k++)
		begin
			{carry_src, cell_input_two, cell_input_one} = k[2:0];
			tick();
			check_bit(local_out, ^k[2:0]);
			check_bit(carry_out, k == 3 || k > 4);
		end
		cascade_use = 1'h1;
		cascade_src = 1'h0;
		tick();
		check_bit(cascade_out, 1'h0);
		check_bit(carry_out, 1'h1);
		reg_bypass = 1'h0;
		{carry_src, cell_input_two, cell_input_one} = 3'h1;
		tick();
		check_bit(reg_q, 1'h1);
		check_bit(local_out, 1'h1);
		{carry_src, cell_input_two, cell_input_one} = 3'h0;
		enable_from_one = 1'h1;
		tick();
		check_bit(reg_q, 1'h1);
		enable_from_one = 1'h0;
		ce = 1'h0;
		tick();
		check_bit(reg_q, 1'h1);
		ce = 1'h1;
		tick();
		check_bit(reg_q, 1'h0);
		$display("arithmetic mode done");
	endtask

	task automatic t_pack;
		mode = MODE_NORMAL;
		cascade_use = 1'h0;
		carry_select = 1'h0;
		packing = 1'h1;
		packed_reg_global = 1'h1;
		lut_mask = 16'h0080;
		{cell_input_three, cell_input_two, cell_input_one} = 3'h7;
		cell_input_four = 1'h1;
		tick();
		check_bit(global_out, 1'h1);
		check_bit(local_out, 1'h1);
		cell_input_four = 1'h0;
		tick();
		check_bit(global_out, 1'h0);
		check_bit(local_out, 1'h1);
		packed_reg_global = 1'h0;
		cell_input_three = 1'h0;
		preset_n = 1'h0;
		tick();
		check_bit(local_out, 1'h1);
		check_bit(global_out, 1'h0);
		clear_n = 1'h0;
		tick();
		check_bit(reg_q, 1'h0);
		{clear_n, preset_n} = 2'h3;
		packing = 1'h0;
		$display("packing done");
	endtask

	task automatic t_counter;
		mode = MODE_UPDOWN;
		{cell_input_three, cell_input_four} = 2'h2;
		{cell_input_two, carry_src, cascade_src} = 3'h7;
		tick();
		cell_input_three = 1'h0;
		#2 check_bit(carry_out, 1'h0);
		tick();
		check_bit(reg_q, 1'h1);
		check_bit(carry_out, 1'h1);
		cascade_src = 1'h0;
		#2 check_bit(carry_out, 1'h0);
		tick();
		check_bit(reg_q, 1'h0);
		cell_input_two = 1'h0;
		tick();
		check_bit(reg_q, 1'h0);
		{cell_input_three, cell_input_four} = 2'h3;
		tick();
		check_bit(reg_q, 1'h1);
		mode = MODE_CLEARABLE;
		{cell_input_three, cell_input_two, carry_src} = 3'h2;
		cascade_src = 1'h1;
		tick();
		check_bit(reg_q, 1'h1);
		cascade_src = 1'h0;
		tick();
		check_bit(reg_q, 1'h0);
		$display("counter modes done");
	endtask

	task automatic chain(input logic [5:0] c, input logic [2:0] s,
		input logic lk, input logic [5:0] nx);
		cluster_index = c;
		cell_slot = s;
		tick();
		check_bit(chain_link, lk);
		if (lk)
			check(chain_next_cluster, nx);
	endtask

	task automatic t_chain;
		chain(6'h01, 3'h7, 1'b1, 6'h03);
		chain(6'h11, 3'h7, 1'b0, 6'h00);
		chain(6'h12, 3'h7, 1'b0, 6'h00);
		chain(6'h13, 3'h7, 1'b1, 6'h15);
		chain(6'h05, 3'h3, 1'b1, 6'h05);
		$display("chain links done");
	endtask

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial
	begin
		#100us;
		n_fail++;
		give_verdict();
	end

	initial
	begin
		{rst, ce, clear_n, preset_n, reg_bypass} = 5'h1f;
		{carry_select, cascade_use, cascade_or, packing} = 4'h0;
		{packed_reg_global, enable_from_one, carry_src, cascade_src} = 4'h0;
		{cell_input_one, cell_input_two} = 2'h0;
		{cell_input_three, cell_input_four} = 2'h0;
		mode = MODE_NORMAL;
		lut_mask = 16'h0000;
		cluster_index = 6'h01;
		cell_slot = 3'h0;
		repeat (10) tick();
		rst = 1'b0;
		check_bit(reg_q, 1'h0);
		t_normal();
		t_arith();
		t_pack();
		t_counter();
		t_chain();
		give_verdict();
	end
endmodule

// file: tb/neighbour_cell.sv
// Lower-order neighbour cell that feeds this cell's chain inputs.
// Assumes the bench sets what the neighbour would produce.
`timescale 1ns/1ps

module neighbour_cell
(
	input  wire logic carry_src,
	input  wire logic cascade_src,
	output logic      carry_in,
	output logic      cascade_in
);
	// Chains are dedicated wires, no register between cells
	assign carry_in   = carry_src;
	assign cascade_in = cascade_src;
endmodule
